// ### hdl/dhcp_port.sv
// Purpose: Debug host communication port behind the scan tap
// Assumes: TCK far slower than REF_CLK; APP_RESET and app ports on REF_CLK
// Notes: Frame is 8 opcode bits, one acknowledge slot, then 32-bit words
// How it works
// - Aborted block read may leave pointer advanced.
// - Application reset reported as busy until supervisor query.
// - Accept decision at opcode end; later resets deferred.
// - Comm read during reset may leave flag set.
// - Read-only version in low byte, fixed address.
// - Scan identity present only when version reaches threshold.
// - Scan identity readable at fixed address.
`timescale 1ns/1ps
module dhcp_port #(
   parameter logic [7:0] VERSION = 8'h50,
   // Arbitrary value
   parameter logic [31:0] SCAN_ID = 32'h0a5c1d01
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // Scan tap pins
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   output logic TDO,
   output logic TDO_OE_N,
   // System read port
   input wire logic SYS_RD,
   input wire logic [31:0] SYS_ADDR,
   output logic SYS_RVALID,
   output logic [31:0] SYS_RDATA,
   // Application side
   input wire logic APP_RESET,
   input wire logic COMM_CLEAR,
   input wire logic [31:0] APP_DATA,
   output logic HOST_READ_REQ,
   output logic HOST_WRITE_PEND,
   output logic [31:0] HOST_WRITE_DATA
);
   dhcp_pkg::dhcp_jtag_t pin_s1;
   dhcp_pkg::dhcp_jtag_t pin_s2;
   logic tck_d;
   dhcp_pkg::dhcp_tap_t tap;
   dhcp_pkg::dhcp_stage_t stage;
   logic [2:0] hdr_cnt;
   logic [4:0] bit_cnt;
   logic [7:0] op_sr;
   logic [7:0] cur_op;
   logic [31:0] in_sr;
   logic [31:0] out_sr;
   logic ack;
   logic reset_seen;
   logic error;
   logic [31:0] io_address_pointer;
   logic [31:0] mem_rdata;
   logic tck_rise;
   logic tck_fall;
   logic shifting;
   logic decide;
   logic accept;
   logic word_done;
   logic fetch;
   logic mem_wr;
   logic known_op;
   logic [7:0] op_now;
   logic [31:0] word_in;
   logic [31:0] debug_info_register;

   function automatic dhcp_pkg::dhcp_tap_t tap_next(input dhcp_pkg::dhcp_tap_t s, input logic tms);
      unique case (s)
         dhcp_pkg::TAP_RESET: tap_next = tms ? dhcp_pkg::TAP_RESET : dhcp_pkg::TAP_IDLE;
         dhcp_pkg::TAP_IDLE: tap_next = tms ? dhcp_pkg::TAP_SEL_DR : dhcp_pkg::TAP_IDLE;
         dhcp_pkg::TAP_SEL_DR: tap_next = tms ? dhcp_pkg::TAP_SEL_IR : dhcp_pkg::TAP_CAP_DR;
         dhcp_pkg::TAP_CAP_DR: tap_next = tms ? dhcp_pkg::TAP_EXIT1_DR : dhcp_pkg::TAP_SHIFT_DR;
         dhcp_pkg::TAP_SHIFT_DR: tap_next = tms ? dhcp_pkg::TAP_EXIT1_DR : dhcp_pkg::TAP_SHIFT_DR;
         dhcp_pkg::TAP_EXIT1_DR: tap_next = tms ? dhcp_pkg::TAP_UPD_DR : dhcp_pkg::TAP_PAUSE_DR;
         dhcp_pkg::TAP_PAUSE_DR: tap_next = tms ? dhcp_pkg::TAP_EXIT2_DR : dhcp_pkg::TAP_PAUSE_DR;
         dhcp_pkg::TAP_EXIT2_DR: tap_next = tms ? dhcp_pkg::TAP_UPD_DR : dhcp_pkg::TAP_SHIFT_DR;
         dhcp_pkg::TAP_UPD_DR: tap_next = tms ? dhcp_pkg::TAP_SEL_DR : dhcp_pkg::TAP_IDLE;
         dhcp_pkg::TAP_SEL_IR: tap_next = tms ? dhcp_pkg::TAP_RESET : dhcp_pkg::TAP_CAP_IR;
         dhcp_pkg::TAP_CAP_IR: tap_next = tms ? dhcp_pkg::TAP_EXIT1_IR : dhcp_pkg::TAP_SHIFT_IR;
         dhcp_pkg::TAP_SHIFT_IR: tap_next = tms ? dhcp_pkg::TAP_EXIT1_IR : dhcp_pkg::TAP_SHIFT_IR;
         dhcp_pkg::TAP_EXIT1_IR: tap_next = tms ? dhcp_pkg::TAP_UPD_IR : dhcp_pkg::TAP_PAUSE_IR;
         dhcp_pkg::TAP_PAUSE_IR: tap_next = tms ? dhcp_pkg::TAP_EXIT2_IR : dhcp_pkg::TAP_PAUSE_IR;
         dhcp_pkg::TAP_EXIT2_IR: tap_next = tms ? dhcp_pkg::TAP_UPD_IR : dhcp_pkg::TAP_SHIFT_IR;
         dhcp_pkg::TAP_UPD_IR: tap_next = tms ? dhcp_pkg::TAP_SEL_DR : dhcp_pkg::TAP_IDLE;
      endcase
   endfunction

   // Pins pass two flops; third flop only for TCK edge detection
   always_ff @(posedge REF_CLK) begin
      pin_s1 <= {TCK, TMS, TDI};
      pin_s2 <= pin_s1;
      tck_d <= pin_s2.tck;
   end

   assign tck_rise = pin_s2.tck && !tck_d;
   assign tck_fall = !pin_s2.tck && tck_d;
   assign shifting = tck_rise && (tap == dhcp_pkg::TAP_SHIFT_DR);
   assign op_now = {pin_s2.tdi, op_sr[7:1]};
   assign word_in = {pin_s2.tdi, in_sr[31:1]};
   assign decide = shifting && (stage == dhcp_pkg::DHCP_HDR) && (hdr_cnt == dhcp_pkg::OPCODE_LAST);
   assign accept = !reset_seen || (op_now == dhcp_pkg::OP_SUPERVISOR);
   assign word_done = shifting && (stage == dhcp_pkg::DHCP_DATA) && (bit_cnt == dhcp_pkg::WORD_LAST);
   assign known_op = (op_now != dhcp_pkg::OP_NONE) && (op_now <= dhcp_pkg::OP_COMM_WRITE_WORD);
   assign fetch = (decide && accept && ((op_now == dhcp_pkg::OP_READ_WORD) || (op_now == dhcp_pkg::OP_READ_BLOCK)))
                  || (word_done && (cur_op == dhcp_pkg::OP_READ_BLOCK));
   assign mem_wr = word_done && (cur_op == dhcp_pkg::OP_WRITE_WORD);
   always_comb begin
      debug_info_register = dhcp_pkg::RESET_DATA;
      debug_info_register[dhcp_pkg::INFO_RESET_SEEN] = reset_seen;
      debug_info_register[dhcp_pkg::INFO_ERROR] = error;
      debug_info_register[dhcp_pkg::INFO_READ_REQ] = HOST_READ_REQ;
      debug_info_register[dhcp_pkg::INFO_WRITE_PEND] = HOST_WRITE_PEND;
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         tap <= dhcp_pkg::TAP_RESET;
      end else if (tck_rise) begin
         tap <= tap_next(tap, pin_s2.tms);
      end
   end

   // Frame sequencing: opcode bits, acknowledge slot, data words
   always_ff @(posedge REF_CLK) begin
      if (RESET || (tck_rise && tap == dhcp_pkg::TAP_CAP_DR)) begin
         stage <= dhcp_pkg::DHCP_HDR;
         hdr_cnt <= 3'h0;
         bit_cnt <= 5'h0;
         op_sr <= 8'h00;
         cur_op <= dhcp_pkg::OP_NONE;
         in_sr <= 32'h00000000;
         out_sr <= 32'h00000000;
         ack <= 1'b0;
      end else if (decide) begin
         // Accept or reject is fixed here; a later reset waits for the next frame
         stage <= dhcp_pkg::DHCP_ACKB;
         ack <= accept;
         cur_op <= accept ? op_now : dhcp_pkg::OP_NONE;
         if (op_now == dhcp_pkg::OP_SUPERVISOR) begin
            out_sr <= debug_info_register;
         end else if (op_now == dhcp_pkg::OP_COMM_READ_WORD) begin
            out_sr <= APP_DATA;
         end else begin
            out_sr <= mem_rdata;
         end
      end else if (shifting) begin
         unique case (stage)
            dhcp_pkg::DHCP_HDR: begin
               op_sr <= op_now;
               hdr_cnt <= hdr_cnt + 3'h1;
            end
            dhcp_pkg::DHCP_ACKB: begin
               stage <= dhcp_pkg::DHCP_DATA;
            end
            dhcp_pkg::DHCP_DATA: begin
               in_sr <= word_in;
               bit_cnt <= bit_cnt + 5'h1;
               out_sr <= {1'b0, out_sr[31:1]};
               if (word_done) begin
                  if (cur_op == dhcp_pkg::OP_READ_BLOCK) begin
                     out_sr <= mem_rdata;
                  end else begin
                     cur_op <= dhcp_pkg::OP_NONE;
                  end
               end
            end
            default: begin
               stage <= dhcp_pkg::DHCP_HDR;
            end
         endcase
      end
   end

   // Pointer advances at each fetch, so a block read cut short still leaves it moved
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         io_address_pointer <= 32'h00000000;
      end else if (word_done && cur_op == dhcp_pkg::OP_SET_ADDRESS) begin
         io_address_pointer <= word_in;
      end else if (fetch || mem_wr) begin
         io_address_pointer <= io_address_pointer + dhcp_pkg::PTR_STEP;
      end
   end

   dhcp_mem u_mem (
      .clk(REF_CLK),
      .addr(io_address_pointer[dhcp_pkg::MEM_AW-1:0]),
      .wr(mem_wr),
      .wdata(word_in),
      .rdata(mem_rdata)
   );

   // Reset report stays until the supervisor query; a new reset wins over its clear
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         reset_seen <= 1'b0;
         error <= 1'b0;
      end else begin
         if (APP_RESET) begin
            reset_seen <= 1'b1;
         end else if (decide && op_now == dhcp_pkg::OP_SUPERVISOR) begin
            reset_seen <= 1'b0;
         end
         if (decide && accept && !known_op) begin
            error <= 1'b1;
         end else if (decide && op_now == dhcp_pkg::OP_SUPERVISOR) begin
            error <= 1'b0;
         end
      end
   end

   // Comm requests survive an application reset; only the clear control drops them
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         HOST_READ_REQ <= 1'b0;
         HOST_WRITE_PEND <= 1'b0;
         HOST_WRITE_DATA <= 32'h00000000;
      end else begin
         if (decide && accept && op_now == dhcp_pkg::OP_COMM_READ_WORD) begin
            HOST_READ_REQ <= 1'b1;
         end else if (COMM_CLEAR) begin
            HOST_READ_REQ <= 1'b0;
         end
         if (word_done && cur_op == dhcp_pkg::OP_COMM_WRITE_WORD) begin
            HOST_WRITE_PEND <= 1'b1;
            HOST_WRITE_DATA <= word_in;
         end else if (COMM_CLEAR) begin
            HOST_WRITE_PEND <= 1'b0;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         TDO <= 1'b0;
         TDO_OE_N <= 1'b1;
      end else if (tck_fall) begin
         TDO_OE_N <= (tap != dhcp_pkg::TAP_SHIFT_DR);
         TDO <= (stage == dhcp_pkg::DHCP_ACKB) ? ack : out_sr[0];
      end
   end

   // System read port: version and scan identity
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         SYS_RVALID <= 1'b0;
         SYS_RDATA <= dhcp_pkg::RESET_DATA;
      end else begin
         SYS_RVALID <= SYS_RD;
         SYS_RDATA <= dhcp_pkg::RESET_DATA;
         if (SYS_RD && SYS_ADDR == dhcp_pkg::ADDR_DEBUG_PORT_VERSION) begin
            SYS_RDATA[dhcp_pkg::VERSION_LSB +: dhcp_pkg::VERSION_W] <= VERSION;
         end else if (SYS_RD && SYS_ADDR == dhcp_pkg::ADDR_SCAN_IDENTITY && VERSION >= dhcp_pkg::VERSION_SCAN_ID_MIN) begin
            SYS_RDATA <= SCAN_ID;
         end
      end
   end

   sequence s_reject;
      decide && reset_seen && op_now != dhcp_pkg::OP_SUPERVISOR;
   endsequence
   sequence s_block_fetch;
      fetch && !mem_wr && !(word_done && cur_op == dhcp_pkg::OP_SET_ADDRESS);
   endsequence

   a_version_read: assert property (@(posedge REF_CLK) disable iff (RESET)
      SYS_RD && SYS_ADDR == dhcp_pkg::ADDR_DEBUG_PORT_VERSION |=> SYS_RVALID && SYS_RDATA == {24'h000000, VERSION})
      else $error("version register read wrong");
   a_scan_id_read: assert property (@(posedge REF_CLK) disable iff (RESET)
      SYS_RD && SYS_ADDR == dhcp_pkg::ADDR_SCAN_IDENTITY && VERSION >= dhcp_pkg::VERSION_SCAN_ID_MIN
      |=> SYS_RVALID && SYS_RDATA == SCAN_ID)
      else $error("scan identity read wrong");
   a_scan_id_absent: assert property (@(posedge REF_CLK) disable iff (RESET)
      SYS_RD && SYS_ADDR == dhcp_pkg::ADDR_SCAN_IDENTITY && VERSION < dhcp_pkg::VERSION_SCAN_ID_MIN
      |=> SYS_RDATA == dhcp_pkg::RESET_DATA)
      else $error("scan identity visible below threshold");
   a_reject_busy: assert property (@(posedge REF_CLK) disable iff (RESET)
      s_reject |=> !ack && cur_op == dhcp_pkg::OP_NONE && reset_seen)
      else $error("instruction not rejected after reset");
   a_busy_sticky: assert property (@(posedge REF_CLK) disable iff (RESET)
      reset_seen && !(decide && op_now == dhcp_pkg::OP_SUPERVISOR) |=> reset_seen)
      else $error("busy report ended without supervisor query");
   a_decision_held: assert property (@(posedge REF_CLK) disable iff (RESET)
      APP_RESET && stage != dhcp_pkg::DHCP_HDR && !(tck_rise && tap == dhcp_pkg::TAP_CAP_DR)
      |=> $stable(ack) && stage != dhcp_pkg::DHCP_HDR)
      else $error("reset altered an accepted instruction");
   a_block_advance: assert property (@(posedge REF_CLK) disable iff (RESET)
      s_block_fetch |=> io_address_pointer == $past(io_address_pointer) + dhcp_pkg::PTR_STEP)
      else $error("pointer did not advance on fetch");
   a_flag_survives: assert property (@(posedge REF_CLK) disable iff (RESET)
      HOST_READ_REQ && !COMM_CLEAR |=> HOST_READ_REQ)
      else $error("read request flag lost without clear");
   a_clear_flags: assert property (@(posedge REF_CLK) disable iff (RESET)
      COMM_CLEAR && !decide && !word_done |=> !HOST_READ_REQ && !HOST_WRITE_PEND)
      else $error("request clear did not empty requests");
endmodule

// ### hdl/dhcp_pkg.sv
// Purpose: Shared constants and types for the debug host communication port
// Assumes: 32-bit system data, 16-word debug-reachable memory window
// Notes: Opcode values and the scan-identity address are block-local choices
package dhcp_pkg;
   // System-visible register addresses
   localparam logic [31:0] ADDR_DEBUG_PORT_VERSION = 32'hf0000408;
   localparam logic [31:0] ADDR_SCAN_IDENTITY = 32'hf0000464;
   localparam logic [31:0] RESET_DATA = 32'h00000000;
   // Version field position and the threshold that enables the scan identity
   localparam int VERSION_LSB = 0;
   localparam int VERSION_W = 8;
   localparam logic [7:0] VERSION_SCAN_ID_MIN = 8'h50;
   // Host instruction frame
   localparam int OPCODE_W = 8;
   localparam int WORD_W = 32;
   localparam logic [2:0] OPCODE_LAST = 3'h7;
   localparam logic [4:0] WORD_LAST = 5'h1f;
   localparam int MEM_AW = 4;
   localparam logic [31:0] PTR_STEP = 32'h00000001;
   localparam logic [7:0] OP_NONE = 8'h00;
   localparam logic [7:0] OP_SET_ADDRESS = 8'h01;
   localparam logic [7:0] OP_READ_WORD = 8'h02;
   localparam logic [7:0] OP_WRITE_WORD = 8'h03;
   localparam logic [7:0] OP_READ_BLOCK = 8'h04;
   localparam logic [7:0] OP_SUPERVISOR = 8'h05;
   localparam logic [7:0] OP_COMM_READ_WORD = 8'h06;
   localparam logic [7:0] OP_COMM_WRITE_WORD = 8'h07;
   // Debug info register bit positions
   localparam int INFO_RESET_SEEN = 0;
   localparam int INFO_ERROR = 1;
   localparam int INFO_READ_REQ = 2;
   localparam int INFO_WRITE_PEND = 3;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } dhcp_jtag_t;

   typedef enum logic [1:0] {
      DHCP_HDR = 2'b00,
      DHCP_ACKB = 2'b01,
      DHCP_DATA = 2'b11
   } dhcp_stage_t;

   typedef enum logic [3:0] {
      TAP_RESET = 4'h0,
      TAP_IDLE = 4'h1,
      TAP_SEL_DR = 4'h3,
      TAP_CAP_DR = 4'h2,
      TAP_SHIFT_DR = 4'h6,
      TAP_EXIT1_DR = 4'h7,
      TAP_PAUSE_DR = 4'h5,
      TAP_EXIT2_DR = 4'h4,
      TAP_UPD_DR = 4'hc,
      TAP_SEL_IR = 4'hd,
      TAP_CAP_IR = 4'hf,
      TAP_SHIFT_IR = 4'he,
      TAP_EXIT1_IR = 4'ha,
      TAP_PAUSE_IR = 4'hb,
      TAP_EXIT2_IR = 4'h9,
      TAP_UPD_IR = 4'h8
   } dhcp_tap_t;
endpackage

// ### hdl/dhcp_mem.sv
// Purpose: Small memory window reached by host read and write instructions
// Assumes: Single clock, write and read on the same address port
// Notes: Read data is registered, one cycle behind the address
`timescale 1ns/1ps
module dhcp_mem (
   // Clock
   input wire logic clk,
   // Access
   input wire logic [dhcp_pkg::MEM_AW-1:0] addr,
   input wire logic wr,
   input wire logic [dhcp_pkg::WORD_W-1:0] wdata,
   output logic [dhcp_pkg::WORD_W-1:0] rdata
);
   logic [dhcp_pkg::WORD_W-1:0] mem [0:(1<<dhcp_pkg::MEM_AW)-1];

   always_ff @(posedge clk) begin
      if (wr) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      rdata <= mem[addr];
   end
endmodule

// ### dv/dhcp_host.sv
// Purpose: Debug host model that drives the scan tap with IO frames
// Assumes: Tap starts in reset or idle; TCK stands low between frames
// Notes: TDO is sampled just before each TCK rise, where it has settled
`timescale 1ns/1ps
module dhcp_host (
   // Clock
   input wire logic clk,
   // Scan tap
   input wire logic tdo,
   input wire logic tdo_oe_n,
   output logic tck,
   output logic tms,
   output logic tdi
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // One 160 ns TCK period: low half, sample, high half
   task automatic tck_cycle(input logic m, input logic d, output logic s);
      tms <= m;
      tdi <= d;
      repeat (8) @(posedge clk);
      s = tdo;
      tck <= 1'b1;
      repeat (8) @(posedge clk);
      tck <= 1'b0;
   endtask
   // Idle, select, capture, shift opcode, ack slot, n data bits, update, idle
   task automatic scan(input logic [7:0] op, input logic [31:0] din, input int n,
                       output logic ack, output logic oe, output logic [31:0] dout);
      logic s;
      int i;
      dout = 32'h0;
      tck_cycle(1'b0, 1'b0, s);
      tck_cycle(1'b1, 1'b0, s);
      tck_cycle(1'b0, 1'b0, s);
      tck_cycle(1'b0, 1'b0, s);
      for (i = 0; i < 8; i++) tck_cycle(1'b0, op[i], s);
      oe = tdo_oe_n;
      tck_cycle(1'b0, 1'b0, ack);
      for (i = 0; i < n; i++) begin
         tck_cycle(i == n - 1, din[i % 32], s);
         dout[i % 32] = s;
      end
      tck_cycle(1'b1, 1'b0, s);
      tck_cycle(1'b0, 1'b0, s);
   endtask
endmodule

// ### dv/testbench.sv
// Purpose: Self-checking bench for the debug host communication port
// Assumes: Host model drives the tap; system reads and app controls come from here
// Notes: A second port below the version threshold shows the missing scan identity
`timescale 1ns/1ps
module testbench;
   localparam logic [31:0] SID = 32'h13572468; // Arbitrary value
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic sys_rd = 1'b0;
   logic [31:0] sys_addr = 32'h0;
   logic app_reset = 1'b0;
   logic comm_clear = 1'b0;
   logic [31:0] app_data = 32'h0;
   logic tck, tms, tdi, tdo, tdo_oe_n, rvalid, rvalid_old, read_req, write_pend, ack, oe;
   logic [31:0] rdata, rdata_old, write_data, dout;
   int failures = 0;
   int checked = 0;
   always #5 ref_clk = ~ref_clk;
   dhcp_port #(.VERSION(8'h50), .SCAN_ID(SID)) dhcp_port_i (.REF_CLK(ref_clk), .RESET(reset), .TCK(tck),
      .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE_N(tdo_oe_n), .SYS_RD(sys_rd), .SYS_ADDR(sys_addr),
      .SYS_RVALID(rvalid), .SYS_RDATA(rdata), .APP_RESET(app_reset), .COMM_CLEAR(comm_clear),
      .APP_DATA(app_data), .HOST_READ_REQ(read_req), .HOST_WRITE_PEND(write_pend), .HOST_WRITE_DATA(write_data));
   dhcp_port #(.VERSION(8'h4f), .SCAN_ID(SID)) dhcp_port_old_i (.REF_CLK(ref_clk), .RESET(reset), .TCK(tck),
      .TMS(tms), .TDI(tdi), .TDO(), .TDO_OE_N(), .SYS_RD(sys_rd), .SYS_ADDR(sys_addr),
      .SYS_RVALID(rvalid_old), .SYS_RDATA(rdata_old), .APP_RESET(app_reset), .COMM_CLEAR(comm_clear),
      .APP_DATA(app_data), .HOST_READ_REQ(), .HOST_WRITE_PEND(), .HOST_WRITE_DATA());
   dhcp_host dhcp_host_i (.clk(ref_clk), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tck(tck), .tms(tms), .tdi(tdi));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic sys_read(input logic [31:0] a, input logic [31:0] e, input logic [31:0] e_old);
      @(posedge ref_clk);
      sys_rd <= 1'b1;
      sys_addr <= a;
      @(posedge ref_clk);
      sys_rd <= 1'b0;
      #1;
      check(rvalid, 32'h1);
      check(rdata, e);
      check(rdata_old, e_old);
      check(rvalid_old, 32'h1);
      @(posedge ref_clk);
      #1;
      check(rvalid, 32'h0);
      check(rdata, 32'h0);
   endtask
   task automatic io(input logic [7:0] op, input logic [31:0] din, input int n, input logic ea);
      @(posedge ref_clk);
      dhcp_host_i.scan(op, din, n, ack, oe, dout);
      check(ack, ea);
      check(oe, 1'b0);
   endtask
   task automatic pulse_comm_clear;
      @(posedge ref_clk);
      comm_clear <= 1'b1;
      @(posedge ref_clk);
      comm_clear <= 1'b0;
   endtask
   task automatic pulse_app_reset;
      @(posedge ref_clk);
      app_reset <= 1'b1;
      @(posedge ref_clk);
      app_reset <= 1'b0;
   endtask
   task automatic t_regs;
      sys_read(dhcp_pkg::ADDR_DEBUG_PORT_VERSION, 32'h50, 32'h4f);
      sys_read(dhcp_pkg::ADDR_SCAN_IDENTITY, SID, 32'h0);
      sys_read(32'hf000040c, 32'h0, 32'h0);
   endtask
   task automatic t_mem;
      io(dhcp_pkg::OP_SET_ADDRESS, 32'h3, 32, 1'b1);
      io(dhcp_pkg::OP_WRITE_WORD, 32'ha5a51234, 32, 1'b1);
      io(dhcp_pkg::OP_WRITE_WORD, 32'h0f1e2d3c, 32, 1'b1);
      io(dhcp_pkg::OP_SET_ADDRESS, 32'h3, 32, 1'b1);
      io(dhcp_pkg::OP_READ_BLOCK, 32'h0, 64, 1'b1);
      check(dout, 32'h0f1e2d3c);
      check(tdo_oe_n, 1'b1);
   endtask
   task automatic t_abort;
      io(dhcp_pkg::OP_SET_ADDRESS, 32'h3, 32, 1'b1);
      io(dhcp_pkg::OP_READ_BLOCK, 32'h0, 8, 1'b1);
      io(dhcp_pkg::OP_READ_WORD, 32'h0, 32, 1'b1);
      check(dout, 32'h0f1e2d3c);
      io(dhcp_pkg::OP_SET_ADDRESS, 32'h3, 32, 1'b1);
      io(dhcp_pkg::OP_READ_WORD, 32'h0, 32, 1'b1);
      check(dout, 32'ha5a51234);
   endtask
   task automatic t_reset;
      // Reset lands after the eighth opcode rise, during the ack slot
      fork
         io(dhcp_pkg::OP_READ_WORD, 32'h0, 32, 1'b1);
         begin
            repeat (200) @(posedge ref_clk);
            pulse_app_reset();
         end
      join
      check(dout, 32'h0f1e2d3c);
      io(dhcp_pkg::OP_READ_WORD, 32'h0, 32, 1'b0);
      io(dhcp_pkg::OP_WRITE_WORD, 32'h0, 32, 1'b0);
      io(dhcp_pkg::OP_SUPERVISOR, 32'h0, 32, 1'b1);
      check(dout[3:0], 4'h1);
      pulse_comm_clear();
      #1;
      check(read_req, 1'b0);
      io(dhcp_pkg::OP_READ_WORD, 32'h0, 32, 1'b1);
   endtask
   task automatic t_comm;
      @(posedge ref_clk);
      app_data <= 32'h13579bdf;
      io(dhcp_pkg::OP_COMM_READ_WORD, 32'h0, 32, 1'b1);
      check(dout, 32'h13579bdf);
      check(read_req, 1'b1);
      io(dhcp_pkg::OP_COMM_WRITE_WORD, 32'hcafe0042, 32, 1'b1);
      check(write_pend, 1'b1);
      check(write_data, 32'hcafe0042);
      pulse_app_reset();
      #1;
      check(read_req, 1'b1);
      io(dhcp_pkg::OP_SUPERVISOR, 32'h0, 32, 1'b1);
      check(dout[3:0], 4'hd);
      pulse_comm_clear();
      #1;
      check(read_req, 1'b0);
      check(write_pend, 1'b0);
      io(8'hc3, 32'h0, 32, 1'b1);
      io(dhcp_pkg::OP_SUPERVISOR, 32'h0, 32, 1'b1);
      check(dout[3:0], 4'h2);
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check(tdo_oe_n, 1'b1);
      check(read_req, 1'b0);
      pulse_comm_clear();
      t_regs();
      t_mem();
      t_abort();
      t_reset();
      t_comm();
      report_and_stop();
   end
   initial begin
      repeat (90000) @(posedge ref_clk);
      failures++;
      report_and_stop();
   end
endmodule
